// ==== core/sbcd_status.sv ====
// Diagnostic status word, fault latches and protective shutdowns
// How it works
// - bits 0-4 hold prewarn, LED, supply, switch, watchdog
// - bits 5-9 monitor levels, or wake source
// - bit 11 LIN failure, or LIN wake
// - bit 12 battery undervoltage, or cyclic wake expiry
// - bit 13 battery overvoltage, low after wake
// - bit 14 supply output fault in both variants
// - bit 15 main undervoltage; host reads twice
// - active-high bits, supply flag low, bit 10 zero
// - undervoltage valid after monitor start-up time
// - no voltage flags outside active mode
// - faults latched until next complete read-out
// - stop mode disables watchdog only if allowed
// - switch fault: switches off, flag, error pulse
// - host error line switches the switches off
// - supply fault shuts output, host re-enables
// - LED fault shuts driver; voltage shutdown optional
// - LIN wake drives receive and data lines low
// - monitor wake drives data output low
// - LIN failure from overtemperature, undervoltage, time-out
// - internal supply undervoltage resets everything
// - watchdog flag cleared by any access
// - only first standby word shows wake source
`timescale 1ns/1ps
module sbcd_status (
  // Core clock and internal-supply reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Serial link pins
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_di,
  output logic            spi_do,
  output logic            spi_do_oe,
  // Operating mode from the mode controller
  input  wire logic       mode_active,
  input  wire logic       mode_standby,
  input  wire logic       mode_saving,
  input  wire logic       mode_stop,
  // Configuration from the control word
  input  wire logic [4:0] mon_enable,
  input  wire logic       led_ovuv_keep,
  input  wire logic       wd_lowpower_en,
  // Re-activation commands, one-cycle pulses
  input  wire logic       ls_reenable,
  input  wire logic       supply_reenable,
  input  wire logic       led_reenable,
  // Events from same-clock logic
  input  wire logic       wd_reset_evt,
  input  wire logic       cyc_wake_evt,
  input  wire logic       spi_fail_in,
  // Analog comparator pins
  input  wire logic       vcc_prewarn,
  input  wire logic       led_fault,
  input  wire logic       ls_fault,
  input  wire logic       supply_fault,
  input  wire logic       vbat_uv,
  input  wire logic       vbat_ov,
  input  wire logic       vs_uv,
  input  wire logic       lin_ot,
  input  wire logic       lin_uv,
  input  wire logic       lin_txd_timeout,
  input  wire logic       lin_wake,
  input  wire logic       vcc_load_low,
  // Wake monitor input pins
  input  wire logic [4:0] wake_monitor_inputs,
  // Error interconnect
  input  wire logic       err_in_n,
  output logic            err_out_n,
  // Protective enables and wake lines
  output logic            low_side_switches_allow,
  output logic            supply_allow,
  output logic            led_high_side_driver_allow,
  output logic            window_watchdog_run,
  output logic            rxd_wake_n
);
  localparam int SYNC_W = 20;
  localparam logic [SYNC_W-1:0] SYNC_INIT = 20'h60000;

  // Synchronised pins
  logic [SYNC_W-1:0] sync_s;
  logic [4:0]  mon_s;
  logic        prewarn_s, led_s, ls_s, sup_s, vbat_uv_s, vbat_ov_s;
  logic        vs_uv_s, lin_ot_s, lin_uv_s, lin_to_s, lin_wake_s;
  logic        load_low_s, err_in_n_s, cs_n_s, done_s;

  // Link carrier between the domains
  sbcd_link_if lnk ();

  // Frame tracking in the core domain
  logic        cs_prev_q;   // Previous synchronised chip select
  logic        done_prev_q; // Previous synchronised done toggle
  logic        start_p;     // Frame start pulse
  logic        done_p;      // Complete frame pulse

  // Fault latches
  logic        prewarn_q, led_lat_q, ls_lat_q, sup_lat_q, wd_flag_q;
  logic        lin_fail_q, vbat_uv_q, vbat_ov_q, vs_uv_q, vint_ok_q;

  // Wake state
  logic [4:0]  mon_prev_q;  // Monitor levels one cycle ago
  logic [4:0]  mon_wake_q;  // Monitor inputs that caused a wake
  logic        lin_wake_prev_q, lin_wake_q, cyc_wake_q;
  logic        wake_first_q; // Next standby word shows the wake source
  logic        do_wake_q;    // Data output held low for a wake
  logic        rxd_wake_q;   // Receive line held low for a LIN wake
  logic        wake_var;     // Wake variant selected now
  logic        mon_wake_ev, lin_wake_ev;

  // Shutdowns and monitoring
  logic        ls_off_q, sup_off_q, led_off_q, err_pulse_q;
  logic        ls_prev_q, spi_fail_q;
  logic [11:0] vmon_cnt_q;
  logic        vmon_ready;
  logic [15:0] status_d, snap_q;

  // Pin synchronisers; chip select and error line idle high
  sbcd_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync (
    .clk (core_clk),
    .rst (rst),
    .d   ({lnk.done_tgl, spi_cs_n, err_in_n, vcc_load_low, lin_wake,
           lin_txd_timeout, lin_uv, lin_ot, vs_uv, vbat_ov, vbat_uv,
           supply_fault, ls_fault, led_fault, vcc_prewarn,
           wake_monitor_inputs}),
    .q   (sync_s)
  );
  assign {done_s, cs_n_s, err_in_n_s, load_low_s, lin_wake_s, lin_to_s,
          lin_uv_s, lin_ot_s, vs_uv_s, vbat_ov_s, vbat_uv_s, sup_s, ls_s,
          led_s, prewarn_s, mon_s} = sync_s;

  // Serial shifter on the link clock
  sbcd_shifter u_shift (
    .spi_sclk (spi_sclk),
    .rst      (rst),
    .spi_cs_n (spi_cs_n),
    .spi_di   (spi_di),
    .lnk      (lnk)
  );

  // Frame start and completion edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_prev_q   <= 1'b1;
      done_prev_q <= 1'b0;
    end else begin
      cs_prev_q   <= cs_n_s;
      done_prev_q <= done_s;
    end
  end
  assign start_p = cs_prev_q & ~cs_n_s;
  assign done_p  = done_prev_q ^ done_s;

  // Voltage monitor start-up counter, runs only in active mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vmon_cnt_q <= 12'h000;
    end else if (!mode_active) begin
      vmon_cnt_q <= 12'h000;
    end else if (vmon_cnt_q != sbcd_pkg::VMON_CNT_MAX) begin
      vmon_cnt_q <= vmon_cnt_q + 12'h001;
    end
  end
  assign vmon_ready = mode_active && vmon_cnt_q == sbcd_pkg::VMON_CNT_MAX;

  // Fault latches; set wins over the read-out clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prewarn_q  <= 1'b0;
      led_lat_q  <= 1'b0;
      ls_lat_q   <= 1'b0;
      sup_lat_q  <= 1'b0;
      lin_fail_q <= 1'b0;
      vbat_uv_q  <= 1'b0;
      vbat_ov_q  <= 1'b0;
      vs_uv_q    <= 1'b0;
    end else begin
      prewarn_q  <= prewarn_s | (prewarn_q & ~done_p);
      led_lat_q  <= led_s | (led_lat_q & ~done_p);
      ls_lat_q   <= ls_s | (ls_lat_q & ~done_p);
      sup_lat_q  <= sup_s | (sup_lat_q & ~done_p);
      lin_fail_q <= lin_ot_s | lin_uv_s | lin_to_s
                    | (lin_fail_q & ~done_p);
      vbat_uv_q  <= (vbat_uv_s & vmon_ready) | (vbat_uv_q & ~done_p);
      vbat_ov_q  <= (vbat_ov_s & vmon_ready) | (vbat_ov_q & ~done_p);
      vs_uv_q    <= (vs_uv_s & vmon_ready) | (vs_uv_q & ~done_p);
    end
  end

  // Watchdog flag cleared by any access; new reset wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wd_flag_q <= 1'b0;
    end else begin
      wd_flag_q <= wd_reset_evt | (wd_flag_q & ~start_p);
    end
  end

  // Supply flag cleared by reset, set after the first read-out
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vint_ok_q <= 1'b0;
    end else if (done_p) begin
      vint_ok_q <= 1'b1;
    end
  end

  // Wake events only in power saving modes
  assign mon_wake_ev = mode_saving && ((mon_s ^ mon_prev_q) & mon_enable)
                                      != 5'h00;
  assign lin_wake_ev = mode_saving & lin_wake_s & ~lin_wake_prev_q;
  assign wake_var    = wake_first_q & mode_standby;

  // Wake source capture; cleared once the wake word is read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mon_prev_q      <= 5'h00;
      lin_wake_prev_q <= 1'b0;
      mon_wake_q      <= 5'h00;
      lin_wake_q      <= 1'b0;
      cyc_wake_q      <= 1'b0;
      wake_first_q    <= 1'b0;
    end else begin
      mon_prev_q      <= mon_s;
      lin_wake_prev_q <= lin_wake_s;
      if (mon_wake_ev || lin_wake_ev || cyc_wake_evt) begin
        mon_wake_q   <= mon_wake_q | (mode_saving ?
                        ((mon_s ^ mon_prev_q) & mon_enable) : 5'h00);
        lin_wake_q   <= lin_wake_q | lin_wake_ev;
        cyc_wake_q   <= cyc_wake_q | cyc_wake_evt;
        wake_first_q <= 1'b1;
      end else if (done_p && wake_var) begin
        mon_wake_q   <= 5'h00;
        lin_wake_q   <= 1'b0;
        cyc_wake_q   <= 1'b0;
        wake_first_q <= 1'b0;
      end
    end
  end

  // Wake signalling lines, released when the host opens a frame
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      do_wake_q  <= 1'b0;
      rxd_wake_q <= 1'b0;
    end else begin
      do_wake_q  <= mon_wake_ev | lin_wake_ev | (do_wake_q & ~start_p);
      rxd_wake_q <= lin_wake_ev | (rxd_wake_q & ~start_p);
    end
  end
  assign rxd_wake_n = ~rxd_wake_q;

  // Switch shutdown on fault or host error line
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ls_off_q    <= 1'b1;
      ls_prev_q   <= 1'b0;
      err_pulse_q <= 1'b0;
    end else begin
      ls_prev_q   <= ls_s;
      err_pulse_q <= ls_s & ~ls_prev_q;
      if (ls_s || !err_in_n_s) begin
        ls_off_q <= 1'b1;
      end else if (ls_reenable) begin
        ls_off_q <= 1'b0;
      end
    end
  end
  assign err_out_n = ~err_pulse_q;

  // Supply output and LED driver shutdowns
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sup_off_q <= 1'b1;
      led_off_q <= 1'b1;
    end else begin
      if (sup_s) begin
        sup_off_q <= 1'b1;
      end else if (supply_reenable) begin
        sup_off_q <= 1'b0;
      end
      if (led_s || (!led_ovuv_keep && vmon_ready
                    && (vbat_uv_s || vbat_ov_s))) begin
        led_off_q <= 1'b1;
      end else if (led_reenable) begin
        led_off_q <= 1'b0;
      end
    end
  end
  assign low_side_switches_allow    = ~ls_off_q;
  assign supply_allow               = ~sup_off_q;
  assign led_high_side_driver_allow = ~led_off_q;

  // Watchdog stops in stop mode only on low load and no request
  assign window_watchdog_run = ~(mode_stop & load_low_s & ~wd_lowpower_en);

  // Status word in either variant
  always_comb begin
    status_d = sbcd_pkg::WORD_RST;
    status_d[sbcd_pkg::POS_VCC_PREWARN] = prewarn_q;
    status_d[sbcd_pkg::POS_LED_FAULT]   = led_lat_q;
    status_d[sbcd_pkg::POS_VINT_OK]     = vint_ok_q;
    status_d[sbcd_pkg::POS_LS_FAULT]    = ls_lat_q;
    status_d[sbcd_pkg::POS_WD_RESET]    = wd_flag_q;
    status_d[sbcd_pkg::POS_MON_LO +: 5] =
      wake_var ? mon_wake_q : (mon_s & mon_enable);
    status_d[sbcd_pkg::POS_RESERVED]    = 1'b0;
    status_d[sbcd_pkg::POS_LIN]     = wake_var ? lin_wake_q : lin_fail_q;
    status_d[sbcd_pkg::POS_VBAT_UV] = wake_var ? cyc_wake_q : vbat_uv_q;
    status_d[sbcd_pkg::POS_VBAT_OV] = ~wake_var & vbat_ov_q;
    status_d[sbcd_pkg::POS_SUP_FAULT]   = sup_lat_q;
    status_d[sbcd_pkg::POS_VS_UV]   = ~wake_var & vs_uv_q;
  end

  // Snapshot frozen while a frame is open
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      snap_q     <= sbcd_pkg::WORD_RST;
      spi_fail_q <= 1'b0;
    end else begin
      spi_fail_q <= spi_fail_in;
      if (cs_n_s) begin
        snap_q <= status_d;
      end
    end
  end
  assign lnk.snap     = snap_q;
  assign lnk.spi_fail = spi_fail_q;

  // Data output: frame data, or low for a pending wake
  assign spi_do    = ~cs_n_s & lnk.tx_bit;
  assign spi_do_oe = ~cs_n_s | do_wake_q;

  // Checks on the core clock
  chk_ls_shutdown: assert property (@(posedge core_clk) disable iff (rst)
    ls_s |=> ls_off_q) else $error("switches not off after fault");
  chk_err_pulse: assert property (@(posedge core_clk) disable iff (rst)
    $rose(ls_s) |=> !err_out_n ##1 err_out_n)
    else $error("error pulse not one cycle");
  chk_err_in_off: assert property (@(posedge core_clk) disable iff (rst)
    !err_in_n_s |=> !low_side_switches_allow)
    else $error("host error did not stop switches");
  chk_supply_off: assert property (@(posedge core_clk) disable iff (rst)
    sup_s |=> !supply_allow ##0 sup_lat_q)
    else $error("supply fault not handled");
  chk_led_ovuv: assert property (@(posedge core_clk) disable iff (rst)
    (vbat_ov_s && vmon_ready && !led_ovuv_keep) |=> led_off_q)
    else $error("LED not off on overvoltage");
  chk_latch_hold: assert property (@(posedge core_clk) disable iff (rst)
    (ls_lat_q && !done_p) |=> ls_lat_q)
    else $error("fault latch lost before read");
  chk_wake_word: assert property (@(posedge core_clk) disable iff (rst)
    wake_var |-> (status_d[13] == 1'b0 && status_d[15] == 1'b0
                  && status_d[9:5] == mon_wake_q))
    else $error("wake word bits wrong");
  chk_wd_clear: assert property (@(posedge core_clk) disable iff (rst)
    (start_p && !wd_reset_evt) |=> !wd_flag_q)
    else $error("watchdog flag not cleared");
  chk_wd_stop: assert property (@(posedge core_clk) disable iff (rst)
    (mode_stop && wd_lowpower_en) |-> window_watchdog_run)
    else $error("watchdog stopped while requested");
  chk_lin_wake: assert property (@(posedge core_clk) disable iff (rst)
    lin_wake_ev |=> (!rxd_wake_n && spi_do_oe && !spi_do))
    else $error("LIN wake not signalled");
  chk_vmon_idle: assert property (@(posedge core_clk) disable iff (rst)
    !mode_active |=> (vmon_cnt_q == 12'h000))
    else $error("voltage monitor active outside active mode");
endmodule : sbcd_status

// ==== core/sbcd_pkg.sv ====
// Constants shared by the diagnostic status word logic
package sbcd_pkg;
  // Status word geometry
  localparam int WORD_W = 16;
  localparam int MON_N  = 5;

  // Bit positions in the status word
  localparam int POS_VCC_PREWARN = 0;
  localparam int POS_LED_FAULT   = 1;
  localparam int POS_VINT_OK     = 2;
  localparam int POS_LS_FAULT    = 3;
  localparam int POS_WD_RESET    = 4;
  localparam int POS_MON_LO      = 5;
  localparam int POS_RESERVED    = 10;
  localparam int POS_LIN         = 11;
  localparam int POS_VBAT_UV     = 12;
  localparam int POS_VBAT_OV     = 13;
  localparam int POS_SUP_FAULT   = 14;
  localparam int POS_VS_UV       = 15;

  // Values after reset, and the count of the last bit
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [4:0]  CNT_RST  = 5'h00;
  localparam logic [4:0]  CNT_LAST = 5'h0F;

  // Voltage monitor start-up time and its cycle count
  localparam int CLK_PERIOD_NS    = 40;
  localparam int VMON_STARTUP_NS  = 100000;
  localparam int VMON_STARTUP_CYC =
    (VMON_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] VMON_CNT_MAX = 12'(VMON_STARTUP_CYC);
endpackage : sbcd_pkg

// ==== core/sbcd_link_if.sv ====
// Signals between the core domain and the serial link domain
`timescale 1ns/1ps
interface sbcd_link_if;
  logic [15:0] snap;      // Frozen status word, core domain
  logic        spi_fail;  // Interface failure indicator, core domain
  logic        done_tgl;  // Toggles after each full 16-bit frame, link
  logic        tx_bit;    // Bit presented on the data output, link

  // Core side of the link
  modport core (output snap, output spi_fail, input done_tgl,
                input tx_bit);
  // Serial shifter side
  modport link (input snap, input spi_fail, output done_tgl,
                output tx_bit);
endinterface : sbcd_link_if

// ==== core/sbcd_sync.sv ====
// Two-flop synchroniser for a vector of levels
`timescale 1ns/1ps
module sbcd_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Levels in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;  // First stage, read only by the second

  // Two stages on the destination clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= INIT;
      q      <= INIT;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : sbcd_sync

// ==== core/sbcd_shifter.sv ====
// Serial shifter clocked by the link clock
`timescale 1ns/1ps
module sbcd_shifter (
  // Link clock and resets
  input  wire logic    spi_sclk,
  input  wire logic    rst,
  // Serial pins
  input  wire logic    spi_cs_n,
  input  wire logic    spi_di,
  // Core side
  sbcd_link_if.link    lnk
);
  logic [4:0]  cnt_q;    // Bits already shifted in this frame
  logic [15:0] shreg_q;  // Remaining bits of the word
  logic        di_q;     // Last bit sampled from the data input
  logic        done_q;   // Frame completion toggle
  logic        frm_rst;  // Clears frame state outside a frame

  assign frm_rst = rst | spi_cs_n;

  // Shift out MSB first; word loaded on first edge
  always_ff @(posedge spi_sclk or posedge frm_rst) begin
    if (frm_rst) begin
      cnt_q   <= sbcd_pkg::CNT_RST;
      shreg_q <= sbcd_pkg::WORD_RST;
      di_q    <= 1'b0;
    end else begin
      di_q <= spi_di;
      if (cnt_q == sbcd_pkg::CNT_RST) begin
        shreg_q <= {lnk.snap[14:0], 1'b0};
      end else begin
        shreg_q <= {shreg_q[14:0], 1'b0};
      end
      if (cnt_q != 5'h10) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // Toggle only when the sixteenth bit is taken
  always_ff @(posedge spi_sclk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (!spi_cs_n && cnt_q == sbcd_pkg::CNT_LAST) begin
      done_q <= ~done_q;
    end
  end

  // Data bit; a failure drives the first bit high once selected, and
  // later bits are ORed with the sampled data input
  assign lnk.tx_bit = ((cnt_q == sbcd_pkg::CNT_RST) ? lnk.snap[15]
                                                    : shreg_q[15])
                      | (lnk.spi_fail
                         & (di_q | (cnt_q == sbcd_pkg::CNT_RST)));
  assign lnk.done_tgl = done_q;
endmodule : sbcd_shifter

// ==== tb/sbcd_host_model.sv ====
// Host serial master model that reads framed status words
`timescale 1ns/1ps
module sbcd_host_model (
  // Serial pins toward the device
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_di,
  // Data returned by the device
  input  wire logic spi_do
);
  // Link clock stands low and nothing is selected between frames
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_di   = 1'b1;
  end

  // One frame of n rising edges at a 30 ns period; bits taken while low
  task automatic frame(input int n, output logic [15:0] w);
    w        = 16'h0000;
    spi_cs_n = 1'b0;
    spi_di   = 1'b0;
    // Give the device time to freeze its snapshot before the first edge
    #200;
    for (int i = 0; i < n; i++) begin
      // Most significant bit comes first
      if (i < 16) begin
        w[15-i] = spi_do;
      end
      #15 spi_sclk = 1'b1;
      #15 spi_sclk = 1'b0;
    end
    #15 spi_cs_n = 1'b1;
    // Deselected data line shows the inverse of what it last carried
    spi_di = 1'b1;
    #200;
  endtask : frame
endmodule : sbcd_host_model

// ==== tb/sbcd_status_tb.sv ====
// Self-checking bench for the diagnostic status word logic
`timescale 1ns/1ps
module sbcd_status_tb;
  // Clock, reset and bookkeeping
  logic        core_clk, rst;
  int          err_count    = 0;
  int          total_checks = 0;
  logic [15:0] w;
  // Serial pins
  logic        spi_sclk, spi_cs_n, spi_di, spi_do, spi_do_oe;
  // Modes and configuration
  logic        mode_active, mode_standby, mode_saving, mode_stop;
  logic [4:0]  mon_enable, wake_monitor_inputs;
  logic        led_ovuv_keep, wd_lowpower_en;
  // Commands and events
  logic        ls_reenable, supply_reenable, led_reenable;
  logic        wd_reset_evt, cyc_wake_evt, spi_fail_in;
  // Comparator pins, grouped for the scenarios
  logic [3:0]  flt;
  logic [2:0]  lin_f;
  logic        vcc_prewarn, led_fault, ls_fault, supply_fault;
  logic        vbat_uv, vbat_ov, vs_uv, lin_ot, lin_uv, lin_txd_timeout;
  logic        lin_wake, vcc_load_low, err_in_n;
  // Outputs
  logic        err_out_n, low_side_switches_allow, supply_allow;
  logic        led_high_side_driver_allow, window_watchdog_run, rxd_wake_n;

  // Fault groups fan out to the individual pins
  assign {supply_fault, ls_fault, led_fault, vcc_prewarn} = flt;
  assign {lin_txd_timeout, lin_uv, lin_ot} = lin_f;

  // Device under test
  sbcd_status dut (
    .core_clk, .rst, .spi_sclk, .spi_cs_n, .spi_di, .spi_do, .spi_do_oe,
    .mode_active, .mode_standby, .mode_saving, .mode_stop, .mon_enable,
    .led_ovuv_keep, .wd_lowpower_en, .ls_reenable, .supply_reenable,
    .led_reenable, .wd_reset_evt, .cyc_wake_evt, .spi_fail_in,
    .vcc_prewarn, .led_fault, .ls_fault, .supply_fault, .vbat_uv,
    .vbat_ov, .vs_uv, .lin_ot, .lin_uv, .lin_txd_timeout, .lin_wake,
    .vcc_load_low, .wake_monitor_inputs, .err_in_n, .err_out_n,
    .low_side_switches_allow, .supply_allow, .led_high_side_driver_allow,
    .window_watchdog_run, .rxd_wake_n
  );
  // Host on the far side of the serial link
  sbcd_host_model host (.spi_sclk, .spi_cs_n, .spi_di, .spi_do);

  // Core clock, 40 ns period
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Wait whole cycles, ending on a falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Full read of one status word
  task automatic rd(input logic [15:0] exp);
    host.frame(16, w);
    cyc(2);
    check(w, exp);
  endtask : rd

  // Protective enables as one value: switches, supply, LED
  function automatic logic [15:0] alw();
    return 16'({low_side_switches_allow, supply_allow,
                led_high_side_driver_allow});
  endfunction : alw

  // Re-activation command pulses
  task automatic reen(input logic [2:0] m);
    {ls_reenable, supply_reenable, led_reenable} = m;
    cyc(1);
    {ls_reenable, supply_reenable, led_reenable} = 3'h0;
    cyc(4);
  endtask : reen

  // One-cycle watchdog reset event
  task automatic wd_pulse;
    wd_reset_evt = 1'b1;
    cyc(1);
    wd_reset_evt = 1'b0;
    cyc(2);
  endtask : wd_pulse

  // Values after reset, first read shows supply fail
  task automatic t_reset;
    check(16'({spi_do_oe, err_out_n, rxd_wake_n}), 16'h0003);
    check(alw(), 16'h0000);
    rd(16'h0000);
    rd(16'h0004);
  endtask : t_reset

  // Latched faults, shutdowns, error line and re-activation
  task automatic t_faults;
    int lows;
    lows = 0;
    reen(3'h7);
    check(alw(), 16'h0007);
    flt = 4'hF;
    repeat (10) begin
      cyc(1);
      if (err_out_n === 1'b0) lows++;
    end
    flt = 4'h0;
    cyc(4);
    check(16'(lows), 16'h0001);
    check(alw(), 16'h0000);
    rd(16'h400F);
    rd(16'h0004);
    reen(3'h4);
    check(alw(), 16'h0004);
    err_in_n = 1'b0;
    cyc(6);
    err_in_n = 1'b1;
    cyc(6);
    check(alw(), 16'h0000);
  endtask : t_faults

  // Watchdog flag and a frame cut short
  task automatic t_short;
    wd_pulse();
    rd(16'h0014);
    wd_pulse();
    flt = 4'h4;
    cyc(6);
    flt = 4'h0;
    cyc(4);
    host.frame(8, w);
    cyc(2);
    rd(16'h000C);
    rd(16'h0004);
  endtask : t_short

  // Monitor levels and each source of a LIN failure
  task automatic t_levels;
    mon_enable = 5'h1F;
    wake_monitor_inputs = 5'h15;
    for (int k = 0; k < 3; k++) begin
      lin_f = 3'(1 << k);
      cyc(6);
      // Cause gone before the read, so the read-out clears the latch
      lin_f = 3'h0;
      cyc(4);
      rd(16'h0AA4);
    end
    rd(16'h02A4);
  endtask : t_levels

  // Wake-ups from monitor, LIN and cyclic timer; stop-mode watchdog
  task automatic t_wake;
    {mode_standby, mode_saving} = 2'b01;
    cyc(10);
    wake_monitor_inputs = 5'h11;
    cyc(6);
    check(16'({spi_do_oe, spi_do}), 16'h0002);
    {mode_standby, mode_saving} = 2'b10;
    cyc(4);
    rd(16'h0084);
    rd(16'h0224);
    {mode_standby, mode_saving} = 2'b01;
    cyc(10);
    lin_wake = 1'b1;
    cyc(6);
    check(16'({spi_do_oe, spi_do, rxd_wake_n}), 16'h0004);
    lin_wake = 1'b0;
    {mode_standby, mode_saving} = 2'b10;
    cyc(4);
    rd(16'h0804);
    {mode_standby, mode_stop} = 2'b01;
    vcc_load_low = 1'b1;
    cyc(6);
    check(16'(window_watchdog_run), 16'h0000);
    wd_lowpower_en = 1'b1;
    cyc(2);
    check(16'(window_watchdog_run), 16'h0001);
    cyc_wake_evt = 1'b1;
    cyc(1);
    cyc_wake_evt = 1'b0;
    {mode_standby, mode_stop} = 2'b10;
    cyc(4);
    rd(16'h1004);
    spi_fail_in = 1'b1;
    cyc(4);
    host.frame(16, w);
    cyc(2);
    check(16'(w[15]), 16'h0001);
    spi_fail_in = 1'b0;
  endtask : t_wake

  // Voltage ranges in active mode, then none in standby
  task automatic t_active;
    {mode_standby, mode_active} = 2'b01;
    reen(3'h1);
    check(alw(), 16'h0001);
    cyc(2600);
    {vbat_uv, vbat_ov, vs_uv} = 3'h7;
    cyc(6);
    check(alw(), 16'h0000);
    rd(16'hB224);
    {vbat_uv, vbat_ov, vs_uv} = 3'h0;
    // LED configured to stay on through battery range faults
    led_ovuv_keep = 1'b1;
    cyc(6);
    reen(3'h1);
    {vbat_uv, vbat_ov, vs_uv} = 3'h7;
    cyc(6);
    check(alw(), 16'h0001);
    {vbat_uv, vbat_ov, vs_uv} = 3'h0;
    cyc(6);
    rd(16'hB224);
    {mode_standby, mode_active} = 2'b10;
    cyc(2);
    {vbat_uv, vbat_ov, vs_uv} = 3'h7;
    cyc(6);
    rd(16'h0224);
  endtask : t_active

  // Verdict and end of run
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    rst = 1'b1;
    {mode_active, mode_saving, mode_stop, mode_standby} = 4'h1;
    {mon_enable, wake_monitor_inputs} = 10'h000;
    {led_ovuv_keep, wd_lowpower_en, vcc_load_low, lin_wake} = 4'h0;
    {ls_reenable, supply_reenable, led_reenable} = 3'h0;
    {wd_reset_evt, cyc_wake_evt, spi_fail_in} = 3'h0;
    {vbat_uv, vbat_ov, vs_uv} = 3'h0;
    flt = 4'h0;
    lin_f = 3'h0;
    err_in_n = 1'b1;
    cyc(12);
    rst = 1'b0;
    cyc(4);
    t_reset();
    t_faults();
    t_short();
    t_levels();
    t_wake();
    t_active();
    conclude();
  end

  // Hang guard, well beyond the expected run of about 130 us
  initial begin
    #1000000;
    err_count++;
    conclude();
  end
endmodule : sbcd_status_tb
